// file: logic/dma_pkg.sv
// dma_pkg.sv: register map, control word layout and shared types of the DMA channels
// assumes one system clock; the registers sit behind an AXI4-Lite slave
package dma_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int         NUM_CH      = 3;
	localparam logic [1:0] LAST_CH     = 2'h2;
	localparam logic [1:0] REG_CTL     = 2'h0;
	localparam logic [1:0] REG_SRC     = 2'h1;
	localparam logic [1:0] REG_DST     = 2'h2;
	localparam logic [1:0] REG_SIZE    = 2'h3;
	localparam logic [7:0] CFG_ADDR    = 8'h30;
	localparam logic [15:0] CTL_RST    = 16'h0000;
	localparam logic [15:0] PTR_RST    = 16'h0000;
	localparam logic [15:0] CTL_WMASK  = 16'h7FFF;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// field codes
	// ---------------------------------------------------------------
	localparam logic [2:0]  MODE_SINGLE     = 3'h0;
	localparam logic [2:0]  MODE_RPT_SINGLE = 3'h4;
	localparam logic [1:0]  STEP_DEC        = 2'h2;
	localparam logic [1:0]  STEP_INC        = 2'h3;
	localparam logic [15:0] BYTE_STEP       = 16'h0001;
	localparam logic [15:0] WORD_STEP       = 16'h0002;

	typedef struct packed {
		logic       reserved_bit;
		logic [2:0] transfer_mode_field;
		logic [1:0] dest_step_select;
		logic [1:0] src_step_select;
		logic       dest_unit_is_byte;
		logic       src_unit_is_byte;
		logic       trigger_level_sense;
		logic       channel_enable_bit;
		logic       channel_done_flag;
		logic       channel_irq_enable;
		logic       channel_abort_flag;
		logic       soft_start_request;
	} ctl_t;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} eng_state_t;

	// byte-lane merge of a register write
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
		input logic [1:0] strb);
		logic [15:0] m;
		m = {{8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (val & m);
	endfunction : merge16

	// one address step; codes 00 and 01 both hold
	function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] sel,
		input logic unit_byte);
		logic [15:0] d;
		d = unit_byte ? BYTE_STEP : WORD_STEP;
		if (sel == STEP_INC)
			return a + d;
		if (sel == STEP_DEC)
			return a - d;
		return a;
	endfunction : step_addr

	// block style modes keep moving until the count runs out
	function automatic logic mode_is_block(input logic [2:0] m);
		return (m != MODE_SINGLE) && (m != MODE_RPT_SINGLE);
	endfunction : mode_is_block

	// repeated modes stay enabled after the count reloads
	function automatic logic mode_repeats(input logic [2:0] m);
		return m[2];
	endfunction : mode_repeats

endpackage : dma_pkg

// file: logic/dma_channels.sv
// dma_channels.sv: three DMA channels, AXI4-Lite registers and a shared mover
// assumes triggers, NMI and memory answers synchronous to I_CLK
`timescale 1ns/10ps
module dma_channels
	import dma_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [7:0]  I_AWADDR,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	output logic [1:0]       O_BRESP,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	input  wire logic [7:0]  I_ARADDR,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	input  wire logic [2:0]  I_TRIG,
	input  wire logic        I_NMI,
	output logic             O_MEM_REQ,
	output logic             O_MEM_WE,
	output logic             O_MEM_BYTE,
	output logic [15:0]      O_MEM_ADDR,
	output logic [15:0]      O_MEM_WDATA,
	input  wire logic        I_MEM_ACK,
	input  wire logic [15:0] I_MEM_RDATA,
	output logic [2:0]       O_IRQ
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [7:0]  aw_addr_reg;
	logic [15:0] w_data_reg;
	logic [1:0]  w_strb_reg;
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	logic        nmi_abort_enable_reg;
	logic        nmi_seen_reg;
	logic [2:0]  irq_reg;
	eng_state_t  state_reg;
	logic [1:0]  sel_reg;
	logic        mem_req_reg;
	logic        mem_we_reg;
	logic        mem_byte_reg;
	logic [15:0] mem_addr_reg;
	logic [15:0] mem_wdata_reg;

	ctl_t        ctl_reg      [NUM_CH];
	logic [15:0] src_reg      [NUM_CH];
	logic [15:0] dst_reg      [NUM_CH];
	logic [15:0] size_reg     [NUM_CH];
	logic [15:0] cnt_reg      [NUM_CH];
	logic [15:0] src_work_reg [NUM_CH];
	logic [15:0] dst_work_reg [NUM_CH];
	logic        blk_reg      [NUM_CH];
	logic        edge_pend_reg[NUM_CH];
	logic        trig_prev_reg[NUM_CH];
	logic        want         [NUM_CH];
	logic        start        [NUM_CH];
	logic        done         [NUM_CH];

	logic        wr_go;
	logic        wr_ch_hit;
	logic        wr_cfg_hit;
	logic [1:0]  wr_ch;
	logic [1:0]  wr_idx;
	logic [1:0]  rd_ch;
	logic [1:0]  rd_idx;
	logic        rd_ch_hit;
	logic        rd_ok;
	logic [31:0] rd_word;
	logic [1:0]  grant;
	logic        any_want;
	logic        abort_now;
	logic [7:0]  rd_byte;
	logic [15:0] rd_unit;
	logic [15:0] wr_unit;

	assign O_AWREADY   = awready_reg;
	assign O_WREADY    = wready_reg;
	assign O_BVALID    = bvalid_reg;
	assign O_BRESP     = bresp_reg;
	assign O_ARREADY   = arready_reg;
	assign O_RVALID    = rvalid_reg;
	assign O_RDATA     = rdata_reg;
	assign O_RRESP     = rresp_reg;
	assign O_MEM_REQ   = mem_req_reg;
	assign O_MEM_WE    = mem_we_reg;
	assign O_MEM_BYTE  = mem_byte_reg;
	assign O_MEM_ADDR  = mem_addr_reg;
	assign O_MEM_WDATA = mem_wdata_reg;
	assign O_IRQ       = irq_reg;

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	// ---------------------------------------------------------------
	// register bus, write side
	// ---------------------------------------------------------------
	// address and data are parked until both are in, so order does not matter
	assign wr_go      = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_ch      = aw_addr_reg[5:4];
	assign wr_idx     = aw_addr_reg[3:2];
	assign wr_ch_hit  = wr_go && (aw_addr_reg[7:6] == 2'h0) && (wr_ch <= LAST_CH) && (aw_addr_reg[1:0] == 2'h0);
	assign wr_cfg_hit = wr_go && (aw_addr_reg == CFG_ADDR);

	// write channel handshakes and response
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 16'h0000;
			w_strb_reg  <= 2'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end
		else
		begin
			if (I_AWVALID && awready_reg)
			begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= I_AWADDR;
				awready_reg <= 1'b0;
			end
			if (I_WVALID && wready_reg)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= I_WDATA[15:0];
				w_strb_reg <= I_WSTRB[1:0];
				wready_reg <= 1'b0;
			end
			if (wr_go)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= (wr_ch_hit || wr_cfg_hit) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_reg && I_BREADY)
			begin
				bvalid_reg  <= 1'b0;
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// shared configuration: NMI abort switch
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			nmi_abort_enable_reg <= 1'b0;
		else if (wr_cfg_hit && w_strb_reg[0])
			nmi_abort_enable_reg <= w_data_reg[0];
	end

	// ---------------------------------------------------------------
	// register bus, read side
	// ---------------------------------------------------------------
	assign rd_ch     = I_ARADDR[5:4];
	assign rd_idx    = I_ARADDR[3:2];
	assign rd_ch_hit = (I_ARADDR[7:6] == 2'h0) && (rd_ch <= LAST_CH) && (I_ARADDR[1:0] == 2'h0);

	// read mux; pointers read back as programmed, count reads the live value
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (rd_ch_hit)
		begin
			unique case (rd_idx)
				REG_CTL:  rd_word = {16'h0000, ctl_reg[rd_ch]};
				REG_SRC:  rd_word = {16'h0000, src_reg[rd_ch]};
				REG_DST:  rd_word = {16'h0000, dst_reg[rd_ch]};
				REG_SIZE: rd_word = {16'h0000, cnt_reg[rd_ch]};
			endcase
		end
		else if (I_ARADDR == CFG_ADDR)
			rd_word = {31'h0000_0000, nmi_abort_enable_reg};
		else
			rd_ok = 1'b0;
	end

	// read handshake; data is captured at the address edge
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
		end
		else
		begin
			if (I_ARVALID && arready_reg)
			begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rdata_reg   <= rd_word;
				rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (rvalid_reg && I_RREADY)
			begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// channels
	// ---------------------------------------------------------------
	for (genvar c = 0; c < NUM_CH; c++)
	begin : g_ch
		ctl_t        cr;
		ctl_t        wr_ctl;
		logic        wc_ctl;
		logic        wc_any;
		logic        last;
		logic        trig_hit;

		assign cr     = ctl_reg[c];
		assign wc_any = wr_ch_hit && (wr_ch == 2'(c));
		assign wc_ctl = wc_any && (wr_idx == REG_CTL);
		assign wr_ctl = ctl_t'(merge16(cr, w_data_reg, w_strb_reg) & CTL_WMASK);
		assign last   = (cnt_reg[c] == 16'h0001);

		// edge mode waits on a latched rising edge, level mode on the line itself
		assign trig_hit = cr.trigger_level_sense ? I_TRIG[c] : edge_pend_reg[c];

		// a running block goes on by itself, except a level trigger pauses it
		assign want[c] = cr.channel_enable_bit && (size_reg[c] != 16'h0000)
			&& ((blk_reg[c] && (!cr.trigger_level_sense || I_TRIG[c]))
			|| trig_hit || cr.soft_start_request);

		assign start[c] = (state_reg == ST_IDLE) && any_want && (grant == 2'(c));
		assign done[c]  = (state_reg == ST_WRITE) && I_MEM_ACK && (sel_reg == 2'(c));

		// rising edge catcher; a new edge wins over the clear at start
		always_ff @(posedge I_CLK or posedge I_RST)
		begin
			if (I_RST)
			begin
				trig_prev_reg[c] <= 1'b0;
				edge_pend_reg[c] <= 1'b0;
			end
			else
			begin
				trig_prev_reg[c] <= I_TRIG[c];
				if (start[c])
					edge_pend_reg[c] <= 1'b0;
				if (I_TRIG[c] && !trig_prev_reg[c])
					edge_pend_reg[c] <= 1'b1;
			end
		end

		// control, pointers, count and working copies; hardware sets come last so they win
		always_ff @(posedge I_CLK or posedge I_RST)
		begin
			if (I_RST)
			begin
				ctl_reg[c]      <= ctl_t'(CTL_RST);
				src_reg[c]      <= PTR_RST;
				dst_reg[c]      <= PTR_RST;
				size_reg[c]     <= PTR_RST;
				cnt_reg[c]      <= PTR_RST;
				src_work_reg[c] <= PTR_RST;
				dst_work_reg[c] <= PTR_RST;
				blk_reg[c]      <= 1'b0;
			end
			else
			begin
				if (start[c])
				begin
					ctl_reg[c].soft_start_request <= 1'b0;
					if (mode_is_block(cr.transfer_mode_field))
						blk_reg[c] <= 1'b1;
				end
				if (done[c])
				begin
					src_work_reg[c] <= step_addr(src_work_reg[c], cr.src_step_select,
						cr.src_unit_is_byte);
					dst_work_reg[c] <= step_addr(dst_work_reg[c], cr.dest_step_select,
						cr.dest_unit_is_byte);
					cnt_reg[c] <= cnt_reg[c] - 16'h0001;
				end
				if (done[c] && last)
				begin
					cnt_reg[c]      <= size_reg[c];
					src_work_reg[c] <= src_reg[c];
					dst_work_reg[c] <= dst_reg[c];
					blk_reg[c]      <= 1'b0;
					if (!mode_repeats(cr.transfer_mode_field))
						ctl_reg[c].channel_enable_bit <= 1'b0;
				end
				if (done[c] && abort_now)
				begin
					ctl_reg[c].channel_enable_bit <= 1'b0;
					blk_reg[c]                    <= 1'b0;
				end
				if (wc_ctl)
				begin
					ctl_reg[c] <= wr_ctl;
					// fresh enable restarts from the programmed values
					if (wr_ctl.channel_enable_bit && !cr.channel_enable_bit)
					begin
						cnt_reg[c]      <= size_reg[c];
						src_work_reg[c] <= src_reg[c];
						dst_work_reg[c] <= dst_reg[c];
						blk_reg[c]      <= 1'b0;
					end
				end
				// only software moves the pointers
				if (wc_any && (wr_idx == REG_SRC))
					src_reg[c] <= merge16(src_reg[c], w_data_reg, w_strb_reg);
				if (wc_any && (wr_idx == REG_DST))
					dst_reg[c] <= merge16(dst_reg[c], w_data_reg, w_strb_reg);
				if (wc_any && (wr_idx == REG_SIZE))
				begin
					size_reg[c] <= merge16(size_reg[c], w_data_reg, w_strb_reg);
					cnt_reg[c]  <= merge16(size_reg[c], w_data_reg, w_strb_reg);
				end
				if (done[c] && last)
					ctl_reg[c].channel_done_flag <= 1'b1;
				if (done[c] && abort_now)
					ctl_reg[c].channel_abort_flag <= 1'b1;
			end
		end

		// checks
		req_clear_a:
		assert property (start[c] && !wc_ctl |=> !ctl_reg[c].soft_start_request)
			else $error("start bit not cleared");
		en_gate_a:
		assert property (start[c] |-> $past(cr.channel_enable_bit) || cr.channel_enable_bit)
			else $error("disabled channel started");
		zero_size_a:
		assert property (start[c] |-> size_reg[c] != 16'h0000 && cnt_reg[c] != 16'h0000)
			else $error("zero size started");
		cnt_dec_a:
		assert property (done[c] && !last && !wc_any |=> cnt_reg[c] == $past(cnt_reg[c]) - 16'h0001)
			else $error("count did not step");
		cnt_reload_a:
		assert property (done[c] && last && !wc_any |=> cnt_reg[c] == $past(size_reg[c])
			&& ctl_reg[c].channel_done_flag)
			else $error("count not reloaded");
		irq_raise_a:
		assert property (done[c] && last && cr.channel_irq_enable && !wc_ctl |=> ##1 O_IRQ[c])
			else $error("interrupt not raised");
		ptr_keep_a:
		assert property (done[c] && !wc_any |=> $stable(src_reg[c]) && $stable(dst_reg[c]))
			else $error("pointer moved by transfer");
		dst_step_a:
		assert property (done[c] && !last && !wc_any && cr.dest_step_select == STEP_INC
			&& cr.dest_unit_is_byte |=> dst_work_reg[c] == $past(dst_work_reg[c]) + 16'h0001)
			else $error("destination byte step wrong");
		src_step_a:
		assert property (done[c] && !last && !wc_any && cr.src_step_select == STEP_DEC
			&& !cr.src_unit_is_byte |=> src_work_reg[c] == $past(src_work_reg[c]) - 16'h0002)
			else $error("source word step wrong");
		abort_stop_a:
		assert property (done[c] && abort_now && !wc_ctl |=> ctl_reg[c].channel_abort_flag
			&& !ctl_reg[c].channel_enable_bit)
			else $error("abort did not stop channel");
		single_stop_a:
		assert property (done[c] && last && cr.transfer_mode_field == MODE_SINGLE && !wc_ctl
			|=> !ctl_reg[c].channel_enable_bit)
			else $error("single mode kept running");
		blk_done_c: cover property (done[c] && last && blk_reg[c]);
		abort_c: cover property (done[c] && abort_now);
		soft_c: cover property (start[c] && cr.soft_start_request);
		level_c: cover property (start[c] && cr.trigger_level_sense);
	end

	// ---------------------------------------------------------------
	// mover
	// ---------------------------------------------------------------
	// fixed priority, channel 0 first; a block can be overtaken between units
	always_comb
	begin
		grant    = 2'h0;
		any_want = 1'b0;
		for (int i = NUM_CH - 1; i >= 0; i--)
		begin
			if (want[i])
			begin
				grant    = 2'(i);
				any_want = 1'b1;
			end
		end
	end

	// byte source takes the addressed lane; byte destination gets it on both lanes
	always_comb
	begin
		rd_byte = mem_addr_reg[0] ? I_MEM_RDATA[15:8] : I_MEM_RDATA[7:0];
		rd_unit = mem_byte_reg ? {8'h00, rd_byte} : I_MEM_RDATA;
		wr_unit = ctl_reg[sel_reg].dest_unit_is_byte ? {rd_unit[7:0], rd_unit[7:0]} : rd_unit;
	end

	// an NMI anywhere in the unit counts; the unit itself always finishes
	assign abort_now = nmi_seen_reg || (I_NMI && nmi_abort_enable_reg);

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			nmi_seen_reg <= 1'b0;
		else if ((state_reg == ST_WRITE) && I_MEM_ACK)
			nmi_seen_reg <= 1'b0;
		else if ((state_reg != ST_IDLE) && I_NMI && nmi_abort_enable_reg)
			nmi_seen_reg <= 1'b1;
	end

	// read then write, one unit at a time
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			state_reg     <= ST_IDLE;
			sel_reg       <= 2'h0;
			mem_req_reg   <= 1'b0;
			mem_we_reg    <= 1'b0;
			mem_byte_reg  <= 1'b0;
			mem_addr_reg  <= PTR_RST;
			mem_wdata_reg <= PTR_RST;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					if (any_want)
					begin
						sel_reg      <= grant;
						mem_req_reg  <= 1'b1;
						mem_we_reg   <= 1'b0;
						mem_byte_reg <= ctl_reg[grant].src_unit_is_byte;
						mem_addr_reg <= src_work_reg[grant];
						state_reg    <= ST_READ;
					end
				end
				ST_READ:
				begin
					if (I_MEM_ACK)
					begin
						mem_we_reg    <= 1'b1;
						mem_byte_reg  <= ctl_reg[sel_reg].dest_unit_is_byte;
						mem_addr_reg  <= dst_work_reg[sel_reg];
						mem_wdata_reg <= wr_unit;
						state_reg     <= ST_WRITE;
					end
				end
				ST_WRITE:
				begin
					if (I_MEM_ACK)
					begin
						mem_req_reg <= 1'b0;
						mem_we_reg  <= 1'b0;
						state_reg   <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// interrupt request lines follow flag and enable
	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
			irq_reg <= 3'h0;
		else
			for (int i = 0; i < NUM_CH; i++)
				irq_reg[i] <= ctl_reg[i].channel_done_flag && ctl_reg[i].channel_irq_enable;
	end

endmodule : dma_channels

// file: tb/dma_mem_model.sv
// dma_mem_model.sv: memory and peripherals on the far side of the mover port
// assumes requests held until ack and one clock shared with the channels
`timescale 1ns/10ps
module dma_mem_model
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_slow,
	output logic             o_ack,
	output logic [15:0]      o_rdata,
	output logic [7:0]       o_wr_count,
	output logic [15:0]      o_last_addr,
	output logic [15:0]      o_last_data
);
	// ---------------------------------------------------------------
	// answer logic
	// ---------------------------------------------------------------
	logic [1:0] wait_reg;

	// ack after zero or three wait cycles; read data is the inverted address
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_ack       <= 1'b0;
			o_rdata     <= 16'h5A5A;
			o_wr_count  <= 8'h00;
			o_last_addr <= 16'h0000;
			o_last_data <= 16'h0000;
			wait_reg    <= 2'h0;
		end
		else
		begin
			o_ack   <= 1'b0;
			o_rdata <= ~o_rdata; // released bus never shows a stale value
			if (i_req && !o_ack)
			begin
				wait_reg <= wait_reg + 2'h1;
				if (wait_reg == (i_slow ? 2'h3 : 2'h0))
				begin
					o_ack    <= 1'b1;
					wait_reg <= 2'h0;
					o_rdata  <= ~i_addr;
					if (i_we)
					begin
						o_wr_count  <= o_wr_count + 8'h01;
						o_last_addr <= i_addr;
						o_last_data <= i_wdata;
					end
				end
			end
		end
	end
endmodule : dma_mem_model

// file: tb/dma_channels_test.sv
// dma_channels_test.sv: self-checking bench for the three DMA channels
// assumes the memory model on the mover port; NMI is raised only in the abort scenario
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end
module dma_channels_test
	import dma_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        nmi = 1'b0, slow = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, wr_count;
	logic [31:0] wdata = 32'h0, rdata;
	logic [2:0]  trig = 3'h0, irq;
	logic        awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_byte, mem_ack;
	logic [1:0]  bresp, rresp;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, last_addr, last_data;
	int          errors = 0, n_checks = 0;

	always #2.5 clk = ~clk;

	dma_channels i_dut (.I_CLK(clk), .I_RST(rst), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
		.I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(4'hF), .O_BVALID(bvalid),
		.I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready), .I_ARADDR(araddr),
		.O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp), .I_TRIG(trig), .I_NMI(nmi),
		.O_MEM_REQ(mem_req), .O_MEM_WE(mem_we), .O_MEM_BYTE(mem_byte), .O_MEM_ADDR(mem_addr),
		.O_MEM_WDATA(mem_wdata), .I_MEM_ACK(mem_ack), .I_MEM_RDATA(mem_rdata), .O_IRQ(irq));

	dma_mem_model i_mem (.i_clk(clk), .i_rst(rst), .i_req(mem_req), .i_we(mem_we), .i_addr(mem_addr),
		.i_wdata(mem_wdata), .i_slow(slow), .o_ack(mem_ack), .o_rdata(mem_rdata), .o_wr_count(wr_count),
		.o_last_addr(last_addr), .o_last_data(last_data));

	// ---------------------------------------------------------------
	// bus tasks
	// ---------------------------------------------------------------
	// address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic aw = 1'b1;
		logic w = 1'b1;
		@(posedge clk);
		awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= {16'h0000, d}; bready <= 1'b1;
		while (aw || w)
		begin
			@(posedge clk);
			aw = aw && !awready;
			w = w && !wready;
			awvalid <= aw;
			wvalid <= w;
		end
		while (!bvalid) @(posedge clk);
		bready <= 1'b0;
		`CHK("bresp", er, bresp)
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [15:0] d, output logic [1:0] r);
		@(posedge clk);
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		d = rdata[15:0];
		r = rresp;
	endtask : axi_rd

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e, input string nm);
		logic [15:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		`CHK(nm, e, d)
	endtask : chk_rd

	// bounded wait for the memory to see n writes
	task automatic wait_wr(input logic [7:0] n);
		for (int i = 0; i < 400 && wr_count !== n; i++) @(posedge clk);
		`CHK("writes", n, wr_count)
	endtask : wait_wr

	task automatic pulse_trig(input logic [2:0] t);
		@(posedge clk);
		trig <= t;
		@(posedge clk);
		trig <= 3'h0;
	endtask : pulse_trig

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// word block, both pointers stepping up, software start
	task automatic t_block;
		logic [15:0] d;
		logic [1:0]  r;
		chk_rd(8'h00, CTL_RST, "ctl reset");
		axi_wr(8'h40, 16'h1234, RESP_SLVERR);
		axi_rd(8'h40, d, r);
		`CHK("unmapped", RESP_SLVERR, r)
		axi_wr(8'h04, 16'h0100, RESP_OKAY);
		axi_wr(8'h08, 16'h0200, RESP_OKAY);
		axi_wr(8'h0C, 16'h0002, RESP_OKAY);
		axi_wr(8'h00, 16'h1F14, RESP_OKAY);
		axi_wr(8'h00, 16'h1F15, RESP_OKAY);
		wait_wr(8'h02);
		`CHK("dst addr", 16'h0202, last_addr)
		`CHK("data", 16'hFEFD, last_data)
		`CHK("word access", 1'b0, mem_byte)
		chk_rd(8'h00, 16'h1F0C, "ctl done");
		chk_rd(8'h04, 16'h0100, "src ptr");
		chk_rd(8'h08, 16'h0200, "dst ptr");
		chk_rd(8'h0C, 16'h0002, "reload");
		`CHK("irq0", 1'b1, irq[0])
	endtask : t_block

	// byte units stepping down, repeated single, rising-edge trigger, slow memory
	task automatic t_repeat;
		slow <= 1'b1;
		axi_wr(8'h14, 16'h0300, RESP_OKAY);
		axi_wr(8'h18, 16'h0401, RESP_OKAY);
		axi_wr(8'h1C, 16'h0002, RESP_OKAY);
		axi_wr(8'h10, 16'h4AD0, RESP_OKAY);
		pulse_trig(3'h2);
		wait_wr(8'h03);
		`CHK("dst byte", 16'h0401, last_addr)
		`CHK("byte access", 1'b1, mem_byte)
		chk_rd(8'h1C, 16'h0001, "live count");
		pulse_trig(3'h2);
		wait_wr(8'h04);
		`CHK("dst dec", 16'h0400, last_addr)
		`CHK("byte data", 16'hFDFD, last_data)
		chk_rd(8'h10, 16'h4AD8, "ctl repeat");
		`CHK("irq1", 1'b0, irq[1])
	endtask : t_repeat

	// disabled channel and zero count must move nothing
	task automatic t_idle;
		axi_wr(8'h2C, 16'h0001, RESP_OKAY);
		axi_wr(8'h20, 16'h0001, RESP_OKAY);
		repeat (20) @(posedge clk);
		`CHK("disabled", 8'h04, wr_count)
		axi_wr(8'h2C, 16'h0000, RESP_OKAY);
		axi_wr(8'h20, 16'h0015, RESP_OKAY);
		repeat (20) @(posedge clk);
		`CHK("zero size", 8'h04, wr_count)
	endtask : t_idle

	// NMI cuts a burst block after one unit, then one plain single transfer
	task automatic t_abort;
		axi_wr(8'h30, 16'h0001, RESP_OKAY);
		chk_rd(8'h30, 16'h0001, "nmi enable");
		axi_wr(8'h04, 16'h0500, RESP_OKAY);
		axi_wr(8'h08, 16'h0600, RESP_OKAY);
		axi_wr(8'h0C, 16'h0003, RESP_OKAY);
		nmi <= 1'b1;
		axi_wr(8'h00, 16'h2E91, RESP_OKAY);
		wait_wr(8'h05);
		repeat (20) @(posedge clk);
		`CHK("abort units", 8'h05, wr_count)
		`CHK("word to byte", 16'hFFFF, last_data)
		chk_rd(8'h00, 16'h2E82, "ctl abort");
		chk_rd(8'h0C, 16'h0002, "abort count");
		nmi <= 1'b0;
		axi_wr(8'h0C, 16'h0001, RESP_OKAY);
		axi_wr(8'h00, 16'h0011, RESP_OKAY);
		wait_wr(8'h06);
		`CHK("single data", 16'hFAFF, last_data)
		chk_rd(8'h00, 16'h0008, "ctl single");
	endtask : t_abort

	task automatic finish_test;
		if (errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	// main sequence after 20 cycles of reset
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_block();
		t_repeat();
		t_idle();
		t_abort();
		finish_test();
	end

	// watchdog well beyond the few hundred cycles needed
	initial
	begin
		#100000;
		errors++;
		finish_test();
	end
endmodule : dma_channels_test
